// [core/swc_pkg.sv]
package swc_pkg;
    // ---------------------------------------------
    // Register map
    // ---------------------------------------------
    localparam logic [7:0] ADDR_FLAGS = 8'h00;
    localparam logic [7:0] ADDR_ENABLE = 8'h04;
    localparam logic [7:0] ADDR_CTRL = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam int FLAG_DONE_BIT = 0;
    localparam int FLAG_COLL_BIT = 1;
    localparam int CTRL_PIN_EN_BIT = 0;
    localparam int CTRL_BOR_EN_BIT = 1;
    localparam int CTRL_WDT_LO = 2;
    localparam int CTRL_SWDT_BIT = 4;
    localparam int CTRL_CLK_LO = 5;
    localparam int CTRL_OST_EN_BIT = 7;
    localparam int STAT_PD_BIT = 0;
    localparam int STAT_TO_BIT = 1;
    localparam int STAT_STATE_LO = 2;
    localparam logic [1:0] FLAGS_RESET = 2'h0;
    localparam logic [1:0] ENABLE_RESET = 2'h0;
    localparam logic [7:0] CTRL_RESET = 8'h8F;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ---------------------------------------------
    // Modes and timing
    // ---------------------------------------------
    localparam logic [1:0] WDT_ALWAYS = 2'h3;
    localparam logic [1:0] WDT_OFF_SLEEP = 2'h2;
    localparam logic [1:0] WDT_SOFT = 2'h1;
    localparam logic [1:0] CLK_INTERNAL = 2'h0;
    localparam int OST_TOSC = 1024;
    localparam int TOSC_NS = 20;
    localparam int CLK_NS = 20;
    localparam int OST_CYCLES = (OST_TOSC * TOSC_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [15:0] ISR_VECTOR = 16'h0004;
    typedef enum logic [1:0] {ST_AWAKE, ST_SLEEP, ST_OST} power_state_type;
endpackage

// [core/sync_stage.sv]
`timescale 1ns/100ps
module sync_stage #(
    parameter int WIDTH = 1
) (
    // Clock
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            meta_r <= '0;
            sync_out <= '0;
        end
        else if (clk_en)
        begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule

// [core/sleep_wake_control.sv]
// Our own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/100ps
module sleep_wake_control #(
    parameter int WAKE_SRCS = 4
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    // Register bus
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // CPU core
    input wire logic sleep_exec,
    input wire logic global_int_enable,
    output logic cpu_clk_en,
    output logic prefetch_next,
    output logic sleep_nop,
    output logic resume_exec,
    output logic isr_call,
    output logic [15:0] isr_vector,
    output logic device_reset,
    // Reset and wake sources
    input wire logic external_reset_pin_n,
    input wire logic brownout_reset,
    input wire logic power_on_reset,
    input wire logic watchdog_timeout,
    input wire logic [WAKE_SRCS-1:0] int_wake_req,
    // Serial port two events
    input wire logic port2_collision_set,
    input wire logic port2_done_set,
    // Watchdog and clocks
    output logic watchdog_clear,
    output logic watchdog_enable,
    output logic low_freq_internal_osc_run,
    output logic timer1_osc_run,
    output logic converter_rc_clock_run,
    output logic sense_osc_run,
    output logic io_hold,
    output logic power_down_flag,
    output logic timeout_flag
);
    // ---------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------
    logic [3:0] pins_s;
    sync_stage #(.WIDTH(4)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .clk_en(clk_en),
        .async_in({watchdog_timeout, power_on_reset, brownout_reset, ~external_reset_pin_n}),
        .sync_out(pins_s)
    );

    // ---------------------------------------------
    // State
    // ---------------------------------------------
    swc_pkg::power_state_type state_r, state_nxt;
    logic [1:0] flags_r, flags_nxt;
    logic [1:0] enable_r;
    logic [7:0] ctrl_r;
    logic pd_r, pd_nxt;
    logic to_r, to_nxt;
    logic [10:0] ost_cnt_r, ost_cnt_nxt;
    logic int_woke_r, int_woke_nxt;
    logic aw_got_r, w_got_r, bvalid_r, rvalid_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r, rdata_r;
    logic [3:0] wstrb_r;
    logic [1:0] bresp_r, rresp_r;
    logic clk_en_r, prefetch_r, nop_r, resume_r, isr_r, reset_r, wdt_clr_r;

    // ---------------------------------------------
    // Decode
    // ---------------------------------------------
    wire [1:0] wdt_mode = ctrl_r[swc_pkg::CTRL_WDT_LO +: 2];
    wire [1:0] clk_mode = ctrl_r[swc_pkg::CTRL_CLK_LO +: 2];
    wire asleep = (state_r == swc_pkg::ST_SLEEP);
    wire wdt_on = (wdt_mode == swc_pkg::WDT_ALWAYS)
        || ((wdt_mode == swc_pkg::WDT_OFF_SLEEP) && !asleep)
        || ((wdt_mode == swc_pkg::WDT_SOFT) && ctrl_r[swc_pkg::CTRL_SWDT_BIT]);
    wire pin_rst = pins_s[0] && ctrl_r[swc_pkg::CTRL_PIN_EN_BIT];
    wire bor_rst = pins_s[1] && ctrl_r[swc_pkg::CTRL_BOR_EN_BIT];
    wire por_rst = pins_s[2];
    wire wdt_evt = pins_s[3] && wdt_on;
    wire full_rst = pin_rst || bor_rst || por_rst;
    wire int_wake = (|int_wake_req) || (|(flags_r & enable_r));
    wire wake_int_or_wdt = int_wake || wdt_evt;
    wire ost_needed = (clk_mode != swc_pkg::CLK_INTERNAL)
        && ctrl_r[swc_pkg::CTRL_OST_EN_BIT];
    wire ost_done = (ost_cnt_r == 11'(swc_pkg::OST_CYCLES - 1));
    wire wr_fire = aw_got_r && w_got_r && !bvalid_r;
    wire wr_flags = wr_fire && (awaddr_r == swc_pkg::ADDR_FLAGS) && wstrb_r[0];
    wire wr_enable = wr_fire && (awaddr_r == swc_pkg::ADDR_ENABLE) && wstrb_r[0];
    wire wr_ctrl = wr_fire && (awaddr_r == swc_pkg::ADDR_CTRL) && wstrb_r[0];
    wire wr_hit = (awaddr_r == swc_pkg::ADDR_FLAGS) || (awaddr_r == swc_pkg::ADDR_ENABLE)
        || (awaddr_r == swc_pkg::ADDR_CTRL) || (awaddr_r == swc_pkg::ADDR_STATUS);
    wire rd_fire = s_axi_arvalid && s_axi_arready;
    wire [7:0] status_word = {4'h0, 2'(state_r), to_r, pd_r};
    wire rd_hit = (s_axi_araddr == swc_pkg::ADDR_FLAGS)
        || (s_axi_araddr == swc_pkg::ADDR_ENABLE)
        || (s_axi_araddr == swc_pkg::ADDR_CTRL)
        || (s_axi_araddr == swc_pkg::ADDR_STATUS);
    wire [7:0] rd_byte =
        (s_axi_araddr == swc_pkg::ADDR_FLAGS) ? {6'h00, flags_r} :
        (s_axi_araddr == swc_pkg::ADDR_ENABLE) ? {6'h00, enable_r} :
        (s_axi_araddr == swc_pkg::ADDR_CTRL) ? ctrl_r :
        (s_axi_araddr == swc_pkg::ADDR_STATUS) ? status_word : 8'h00;
    wire [1:0] hw_set = {port2_collision_set, port2_done_set};

    // ---------------------------------------------
    // Flag register, set wins over clear
    // ---------------------------------------------
    always_comb
    begin
        flags_nxt = flags_r;
        if (wr_flags)
        begin
            flags_nxt = wdata_r[1:0];
        end
        flags_nxt = flags_nxt | hw_set;
    end

    // ---------------------------------------------
    // Power sequencing
    // ---------------------------------------------
    logic enter_sleep, do_wake, do_reset;
    always_comb
    begin
        state_nxt = state_r;
        pd_nxt = pd_r;
        to_nxt = to_r;
        ost_cnt_nxt = ost_cnt_r;
        int_woke_nxt = int_woke_r;
        enter_sleep = 1'b0;
        do_wake = 1'b0;
        do_reset = 1'b0;
        if (full_rst)
        begin
            do_reset = 1'b1;
            state_nxt = swc_pkg::ST_AWAKE;
            pd_nxt = 1'b1;
            to_nxt = 1'b1;
        end
        else
        begin
            case (state_r)
                swc_pkg::ST_AWAKE:
                begin
                    if (wdt_evt)
                    begin
                        do_reset = 1'b1;
                        pd_nxt = 1'b1;
                        to_nxt = 1'b0;
                    end
                    else if (sleep_exec && !global_int_enable && int_wake)
                    begin
                        // Sleep becomes a no-operation; flags untouched
                        int_woke_nxt = 1'b0;
                    end
                    else if (sleep_exec)
                    begin
                        enter_sleep = 1'b1;
                        state_nxt = swc_pkg::ST_SLEEP;
                        pd_nxt = 1'b0;
                        to_nxt = 1'b1;
                    end
                end
                swc_pkg::ST_SLEEP:
                begin
                    if (wake_int_or_wdt)
                    begin
                        do_wake = 1'b1;
                        int_woke_nxt = int_wake;
                        if (wdt_evt && !int_wake)
                        begin
                            to_nxt = 1'b0;
                        end
                        ost_cnt_nxt = 11'h000;
                        state_nxt = ost_needed ? swc_pkg::ST_OST : swc_pkg::ST_AWAKE;
                    end
                end
                swc_pkg::ST_OST:
                begin
                    ost_cnt_nxt = ost_cnt_r + 11'h001;
                    if (ost_done)
                    begin
                        state_nxt = swc_pkg::ST_AWAKE;
                    end
                end
                default:
                begin
                    state_nxt = swc_pkg::ST_AWAKE;
                end
            endcase
        end
    end

    wire resume_now = (do_wake && !ost_needed)
        || ((state_r == swc_pkg::ST_OST) && ost_done && !full_rst);

    // ---------------------------------------------
    // Registers
    // ---------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_r <= swc_pkg::ST_AWAKE;
            flags_r <= swc_pkg::FLAGS_RESET;
            enable_r <= swc_pkg::ENABLE_RESET;
            ctrl_r <= swc_pkg::CTRL_RESET;
            pd_r <= 1'b1;
            to_r <= 1'b1;
            ost_cnt_r <= 11'h000;
            int_woke_r <= 1'b0;
        end
        else if (clk_en)
        begin
            state_r <= state_nxt;
            flags_r <= flags_nxt;
            pd_r <= pd_nxt;
            to_r <= to_nxt;
            ost_cnt_r <= ost_cnt_nxt;
            int_woke_r <= int_woke_nxt;
            if (wr_enable)
            begin
                enable_r <= wdata_r[1:0];
            end
            if (wr_ctrl)
            begin
                ctrl_r <= wdata_r[7:0];
            end
        end
    end

    // ---------------------------------------------
    // CPU and watchdog outputs
    // ---------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            clk_en_r <= 1'b1;
            prefetch_r <= 1'b0;
            nop_r <= 1'b0;
            resume_r <= 1'b0;
            isr_r <= 1'b0;
            reset_r <= 1'b0;
            wdt_clr_r <= 1'b1;
        end
        else if (clk_en)
        begin
            clk_en_r <= (state_nxt == swc_pkg::ST_AWAKE);
            prefetch_r <= enter_sleep;
            nop_r <= sleep_exec && !enter_sleep && (state_r == swc_pkg::ST_AWAKE);
            resume_r <= resume_now;
            isr_r <= resume_now && global_int_enable
                && (do_wake ? int_wake : int_woke_r);
            reset_r <= do_reset;
            // Cleared on entry, on wake and while start-up runs
            wdt_clr_r <= enter_sleep || do_wake || do_reset
                || (state_nxt == swc_pkg::ST_OST);
        end
    end

    assign cpu_clk_en = clk_en_r;
    assign prefetch_next = prefetch_r;
    assign sleep_nop = nop_r;
    assign resume_exec = resume_r;
    assign isr_call = isr_r;
    assign isr_vector = swc_pkg::ISR_VECTOR;
    assign device_reset = reset_r;
    assign watchdog_clear = wdt_clr_r;
    assign watchdog_enable = wdt_on;
    assign low_freq_internal_osc_run = 1'b1;
    assign timer1_osc_run = 1'b1;
    assign converter_rc_clock_run = 1'b1;
    assign sense_osc_run = 1'b1;
    assign io_hold = !clk_en_r;
    assign power_down_flag = pd_r;
    assign timeout_flag = to_r;

    // ---------------------------------------------
    // Register bus slave
    // ---------------------------------------------
    assign s_axi_awready = clk_en && !aw_got_r && !bvalid_r;
    assign s_axi_wready = clk_en && !w_got_r && !bvalid_r;
    assign s_axi_arready = clk_en && !rvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            bvalid_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
            bresp_r <= swc_pkg::RESP_OKAY;
        end
        else if (clk_en)
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_got_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_got_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_hit ? swc_pkg::RESP_OKAY : swc_pkg::RESP_SLVERR;
            end
            else if (bvalid_r && s_axi_bready)
            begin
                bvalid_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h00000000;
            rresp_r <= swc_pkg::RESP_OKAY;
        end
        else if (clk_en)
        begin
            if (rd_fire)
            begin
                rvalid_r <= 1'b1;
                rdata_r <= {24'h000000, rd_byte};
                rresp_r <= rd_hit ? swc_pkg::RESP_OKAY : swc_pkg::RESP_SLVERR;
            end
            else if (rvalid_r && s_axi_rready)
            begin
                rvalid_r <= 1'b0;
            end
        end
    end
endmodule

// [bench/wake_source_model.sv]
`timescale 1ns/100ps
module wake_source_model (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Source events from the bench
    input wire logic [3:0] fire,
    input wire logic [3:0] clr,
    input wire logic [3:0] en,
    // Wake requests
    output logic [3:0] int_wake_req
);
    logic [3:0] flag_r;
    logic [3:0] flag_nxt;

    // Flags latch on their event, enable or not
    assign flag_nxt = (flag_r & ~clr) | fire;
    assign int_wake_req = flag_r & en;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            flag_r <= 4'h0;
        else
            flag_r <= flag_nxt;
    end
endmodule

// [bench/sleep_wake_control_props.sv]
`timescale 1ns/100ps
module sleep_wake_control_props #(
    parameter int WAKE_SRCS = 4
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    // CPU side
    input wire logic sleep_exec,
    input wire logic cpu_clk_en,
    input wire logic prefetch_next,
    input wire logic sleep_nop,
    input wire logic resume_exec,
    input wire logic isr_call,
    input wire logic [15:0] isr_vector,
    input wire logic device_reset,
    input wire logic [WAKE_SRCS-1:0] int_wake_req,
    // Watchdog, clocks and status
    input wire logic watchdog_clear,
    input wire logic low_freq_internal_osc_run,
    input wire logic timer1_osc_run,
    input wire logic converter_rc_clock_run,
    input wire logic sense_osc_run,
    input wire logic io_hold,
    input wire logic power_down_flag,
    input wire logic timeout_flag
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    property p_sleep_only;
        $fell(cpu_clk_en) |-> $past(sleep_exec);
    endproperty
    a_sleep_only: assert property (p_sleep_only) else $error("clock stopped without sleep");

    property p_entry_answer;
        clk_en && sleep_exec && cpu_clk_en |=> prefetch_next ^ sleep_nop;
    endproperty
    a_entry_answer: assert property (p_entry_answer) else $error("sleep not answered");

    property p_entry_state;
        prefetch_next |-> !cpu_clk_en && !power_down_flag && timeout_flag && watchdog_clear;
    endproperty
    a_entry_state: assert property (p_entry_state) else $error("bad sleep entry");

    property p_nop_keeps;
        sleep_nop |-> cpu_clk_en && $stable(power_down_flag) && $stable(timeout_flag);
    endproperty
    a_nop_keeps: assert property (p_nop_keeps) else $error("no-op sleep changed state");

    property p_int_wake;
        clk_en && !cpu_clk_en && !watchdog_clear && |int_wake_req |=> watchdog_clear;
    endproperty
    a_int_wake: assert property (p_int_wake) else $error("enabled source did not wake");

    property p_wake_clear;
        $rose(cpu_clk_en) |-> watchdog_clear || $past(watchdog_clear);
    endproperty
    a_wake_clear: assert property (p_wake_clear) else $error("wake without watchdog clear");

    property p_isr;
        isr_call |-> resume_exec && isr_vector == 16'h0004;
    endproperty
    a_isr: assert property (p_isr) else $error("handler call malformed");

    property p_io_hold;
        io_hold == !cpu_clk_en;
    endproperty
    a_io_hold: assert property (p_io_hold) else $error("pin hold mismatch");

    property p_osc_run;
        low_freq_internal_osc_run && timer1_osc_run && converter_rc_clock_run && sense_osc_run;
    endproperty
    a_osc_run: assert property (p_osc_run) else $error("oscillator stopped");

    property p_full_reset;
        device_reset |-> ##[0:1] (cpu_clk_en && power_down_flag);
    endproperty
    a_full_reset: assert property (p_full_reset) else $error("full reset not applied");
endmodule

bind sleep_wake_control sleep_wake_control_props #(.WAKE_SRCS(WAKE_SRCS)) u_props (.*);

// [bench/sleep_wake_control_tb.sv]
`timescale 1ns/100ps
module sleep_wake_control_tb;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic clk_en = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic sleep_exec = 1'b0, global_int_enable = 1'b0, external_reset_pin_n = 1'b1;
    logic brownout_reset = 1'b0, power_on_reset = 1'b0, watchdog_timeout = 1'b0;
    logic port2_collision_set = 1'b0, port2_done_set = 1'b0;
    logic [3:0] int_wake_req, fire = 4'h0, clr = 4'h0, en = 4'hF;
    logic cpu_clk_en, prefetch_next, sleep_nop, resume_exec, isr_call, device_reset;
    logic [15:0] isr_vector;
    logic watchdog_clear, watchdog_enable, low_freq_internal_osc_run, timer1_osc_run;
    logic converter_rc_clock_run, sense_osc_run, io_hold, power_down_flag, timeout_flag;
    int mismatches = 0;
    int n_tests = 0;
    logic [33:0] rd_q[$];
    logic wk_q[$];
    logic [31:0] seed = 32'h0000002C;

    always #10 aclk = ~aclk;

    sleep_wake_control u_dut (.*);
    wake_source_model u_src (.*);

    // ------------------------------------
    // Helpers
    // ------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic close_out();
        $display("Counts: %0d checks, %0d mismatches", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [33:0] s, input logic [33:0] e);
        n_tests++;
        if (s !== e)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic wt(ref logic s, input int lim, output int c);
        c = 0;
        do
        begin
            @(posedge aclk);
            c++;
        end
        while (s !== 1'b1 && c < lim);
        if (s !== 1'b1)
        begin
            chk("wait bound", 34'(0), 34'(1));
            close_out();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw;
        logic w;
        int c;
        aw = 1'b0;
        w = 1'b0;
        c = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw && w) && c < 50)
        begin
            @(posedge aclk);
            c++;
            if (!aw && s_axi_awready)
            begin
                aw = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w && s_axi_wready)
            begin
                w = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        if (!(aw && w))
        begin
            chk("aw w taken", 34'(0), 34'(1));
            close_out();
        end
        wt(s_axi_bvalid, 50, c);
        s_axi_bready <= 1'b0;
        chk("bresp", 34'(s_axi_bresp), 34'(swc_pkg::RESP_OKAY));
    endtask

    task automatic rd(input logic [7:0] a, input logic [1:0] r, input logic [31:0] d);
        int c;
        rd_q.push_back({r, d});
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        wt(s_axi_arready, 50, c);
        s_axi_arvalid <= 1'b0;
        wt(s_axi_rvalid, 50, c);
        s_axi_rready <= 1'b0;
    endtask

    // Bits: 0 sleep, 1 done, 2 collision, 3 brown-out, 4 watchdog time-out
    task automatic pulse(input logic [4:0] m);
        @(posedge aclk);
        {watchdog_timeout, brownout_reset, port2_collision_set, port2_done_set, sleep_exec} <= m;
        @(posedge aclk);
        {watchdog_timeout, brownout_reset, port2_collision_set, port2_done_set, sleep_exec} <= 5'h00;
    endtask

    task automatic src(input logic [3:0] f);
        @(posedge aclk);
        fire <= f;
        @(posedge aclk);
        fire <= 4'h0;
    endtask

    task automatic slp(input logic nop);
        // Software keeps a no-operation after the sleep instruction
        pulse(5'h01);
        @(posedge aclk);
        chk("prefetch", 34'(prefetch_next), 34'(!nop));
        chk("sleep_nop", 34'(sleep_nop), 34'(nop));
    endtask

    // Results arrive here and meet the oldest note
    always @(posedge aclk)
    begin
        if (s_axi_rvalid && s_axi_rready && rd_q.size() > 0)
            chk("read", {s_axi_rresp, s_axi_rdata}, rd_q.pop_front());
        if (resume_exec === 1'b1)
            chk("isr_call", 34'(isr_call), (wk_q.size() > 0) ? 34'(wk_q.pop_front()) : 34'h3);
    end

    // ------------------------------------
    // Sequence
    // ------------------------------------
    initial
    begin
        int c;
        logic [31:0] r;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        rd(swc_pkg::ADDR_FLAGS, swc_pkg::RESP_OKAY, 32'h0);
        rd(swc_pkg::ADDR_CTRL, swc_pkg::RESP_OKAY, 32'h8F);
        rd(swc_pkg::ADDR_STATUS, swc_pkg::RESP_OKAY, 32'h3);
        rd(8'h10, swc_pkg::RESP_SLVERR, 32'h0);
        chk("watchdog_enable", 34'(watchdog_enable), 34'(1));
        clk_en <= 1'b0;
        @(posedge aclk);
        chk("awready frozen", 34'(s_axi_awready), 34'(0));
        clk_en <= 1'b1;
        $display("Test reset values done");
        pulse(5'h02);
        pulse(5'h04);
        repeat (5) @(posedge aclk);
        rd(swc_pkg::ADDR_FLAGS, swc_pkg::RESP_OKAY, 32'h3);
        wr(swc_pkg::ADDR_FLAGS, 32'h0);
        rd(swc_pkg::ADDR_FLAGS, swc_pkg::RESP_OKAY, 32'h0);
        $display("Test flags done");
        for (int i = 0; i < 4; i++)
        begin
            r = rnd();
            global_int_enable <= r[0];
            slp(1'b0);
            rd(swc_pkg::ADDR_STATUS, swc_pkg::RESP_OKAY, 32'h6);
            chk("io_hold", 34'(io_hold), 34'(1));
            repeat (int'(r[4:1])) @(posedge aclk);
            wk_q.push_back(r[0]);
            src(4'h1 << i);
            wt(resume_exec, 50, c);
            src(4'h0);
            clr <= 4'hF;
            @(posedge aclk);
            clr <= 4'h0;
        end
        $display("Test interrupt wake done");
        global_int_enable <= 1'b0;
        src(4'h4);
        slp(1'b1);
        rd(swc_pkg::ADDR_STATUS, swc_pkg::RESP_OKAY, 32'h2);
        clr <= 4'hF;
        @(posedge aclk);
        clr <= 4'h0;
        wr(swc_pkg::ADDR_ENABLE, 32'h00000001);
        pulse(5'h02);
        slp(1'b1);
        rd(swc_pkg::ADDR_ENABLE, swc_pkg::RESP_OKAY, 32'h1);
        wr(swc_pkg::ADDR_FLAGS, 32'h0);
        wr(swc_pkg::ADDR_ENABLE, 32'h0);
        $display("Test no-op sleep done");
        slp(1'b0);
        wk_q.push_back(1'b0);
        pulse(5'h10);
        wt(resume_exec, 50, c);
        chk("timeout_flag", 34'(timeout_flag), 34'(0));
        rd(swc_pkg::ADDR_STATUS, swc_pkg::RESP_OKAY, 32'h0);
        $display("Test watchdog wake done");
        slp(1'b0);
        pulse(5'h08);
        wt(device_reset, 50, c);
        repeat (2) @(posedge aclk);
        rd(swc_pkg::ADDR_STATUS, swc_pkg::RESP_OKAY, 32'h3);
        $display("Test brown-out wake done");
        wr(swc_pkg::ADDR_CTRL, 32'h0000008B);
        chk("watchdog_enable", 34'(watchdog_enable), 34'(1));
        slp(1'b0);
        chk("watchdog_enable", 34'(watchdog_enable), 34'(0));
        en <= 4'h7;
        pulse(5'h10);
        src(4'h8);
        repeat (4) @(posedge aclk);
        chk("cpu_clk_en", 34'(cpu_clk_en), 34'(0));
        wk_q.push_back(1'b0);
        en <= 4'hF;
        wt(resume_exec, 50, c);
        clr <= 4'hF;
        @(posedge aclk);
        clr <= 4'h0;
        $display("Test masked wake done");
        wr(swc_pkg::ADDR_CTRL, 32'hAF);
        global_int_enable <= 1'b1;
        slp(1'b0);
        wk_q.push_back(1'b1);
        src(4'h2);
        wt(resume_exec, 1500, c);
        chk("startup_wait", 34'(c >= 1024), 34'(1));
        $display("Test crystal start-up done");
        close_out();
    end
endmodule
